//--- hdl/sfcs_consts.svh
`ifndef SFCS_CONSTS_SVH
`define SFCS_CONSTS_SVH

// Register byte offsets on the APB window.
`define SFCS_OFF_RX_CFG 12'h000
`define SFCS_OFF_TX_CFG 12'h004
`define SFCS_OFF_RX_STAT 12'h008
`define SFCS_OFF_CTRL 12'h00C
`define SFCS_OFF_TX_STAT 12'h010
`define SFCS_OFF_IRQ_STAT 12'h014
`define SFCS_OFF_IRQ_MASK 12'h018

// Field positions inside the FIFO configuration registers.
`define SFCS_CFG_CLR_BIT 7
`define SFCS_CFG_SEL_BIT 6
`define SFCS_CFG_LVL_HI 1
`define SFCS_CFG_LVL_LO 0

// Field positions inside the receive status register.
`define SFCS_STAT_OVR_BIT 7
`define SFCS_STAT_LVL_HI 2
`define SFCS_STAT_LVL_LO 0

// Field positions inside the control register.
`define SFCS_CTRL_EN_BIT 0
`define SFCS_CTRL_DPX_HI 2
`define SFCS_CTRL_DPX_LO 1

// Interrupt status and mask bit positions.
`define SFCS_IRQ_RX_BIT 0
`define SFCS_IRQ_TX_BIT 1
`define SFCS_IRQ_OVR_BIT 2

// Reset values and FIFO sizes.
`define SFCS_RST_WORD 32'h0000_0000
`define SFCS_RST_LVL 2'h0
`define SFCS_RST_IRQ 3'h0
`define SFCS_DEPTH_HALF 3'h4
`define SFCS_DEPTH_FULL 3'h2
`define SFCS_DEPTH_NONE 3'h1

`endif

//--- hdl/sfcs_pkg.sv
package sfcs_pkg;

    // Channel direction setting that shapes the FIFO sizes.
    typedef enum logic [1:0] {
        SFCS_DPX_OFF = 2'h0,
        SFCS_DPX_HALF_RX = 2'h1,
        SFCS_DPX_HALF_TX = 2'h2,
        SFCS_DPX_FULL = 2'h3
    } sfcs_duplex_t;

    typedef logic [2:0] sfcs_level_t;

endpackage

//--- hdl/sfcs_fifo.sv
`timescale 1ns/100ps
module sfcs_fifo (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_wr,
    input wire logic [7:0] i_data,
    input wire logic i_rd,
    input wire logic [2:0] i_cap,
    output logic [7:0] o_data,
    output logic o_wr_ok,
    output logic o_rd_ok,
    output logic [2:0] o_level,
    output logic [2:0] o_next_level
);
    logic [7:0] mem [0:3];
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;

    assign o_wr_ok = i_wr && !i_clr && (o_level < i_cap);
    assign o_rd_ok = i_rd && !i_clr && (o_level != 3'h0);
    assign o_next_level = i_clr ? 3'h0 :
        3'(o_level + {2'h0, o_wr_ok} - {2'h0, o_rd_ok});
    assign o_data = mem[rd_ptr];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_entry
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    mem[g] <= 8'h00;
                end else if (o_wr_ok && (wr_ptr == 2'(g))) begin
                    mem[g] <= i_data;
                end
            end
        end
    endgenerate

    // A clear puts both pointers back to the first entry.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clr) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
        end else begin
            if (o_wr_ok) begin
                wr_ptr <= 2'(wr_ptr + 2'h1);
            end
            if (o_rd_ok) begin
                rd_ptr <= 2'(rd_ptr + 2'h1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_level <= 3'h0;
        end else begin
            o_level <= o_next_level;
        end
    end

endmodule

//--- hdl/sfcs_top.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "sfcs_consts.svh"

// Function
// - Writing one to the receive clear bit empties the receive FIFO, zeroes its level and resets its read pointer, and the bit reads as zero.
// - The receive select bit picks a threshold hit only, or also a read that finds the count above the threshold, as the receive interrupt cause.
// - The receive threshold code maps 00,01,10,11 to 4,1,2,3 bytes in half duplex and to 2,1,2,1 bytes in full duplex.
// - Writing one to the transmit clear bit empties the transmit FIFO, zeroes its level and resets its write pointer, and the bit reads as zero.
// - The transmit select bit picks a threshold hit only, or also a drain that leaves the level short of the threshold, as the transmit cause.
// - The transmit threshold code maps 00,01,10,11 to empty,1,2,3 bytes outside full duplex and to empty,1,empty,1 in full duplex.
// - Bit 7 of the receive status register is a read-only flag set once the receive FIFO has overrun.
// - A read-only three-bit receive level field shows 0 for empty and 1 to 4 for the stored byte count.
// - Bits 31 to 8 of the receive configuration register read as zero and ignore writes.
// - With the FIFO enabled the depth is 4 bytes for the active half duplex direction and 2 bytes each in full duplex.
module sfcs_top (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_RX_WR,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_RD,
    output logic [7:0] O_RX_DATA,
    output logic O_RX_READY,
    output logic O_RX_VALID,
    input wire logic I_TX_WR,
    input wire logic [7:0] I_TX_DATA,
    input wire logic I_TX_RD,
    output logic [7:0] O_TX_DATA,
    output logic O_TX_READY,
    output logic O_TX_VALID,
    output logic O_FIFO_ENABLE,
    output sfcs_pkg::sfcs_duplex_t O_DUPLEX_MODE,
    output logic O_IRQ
);
    import sfcs_pkg::*;

    logic setup;
    logic access;
    logic wr_en;
    logic hit;
    logic rx_clr;
    logic tx_clr;
    logic rx_cond_sel;
    logic [1:0] rx_irq_level;
    logic tx_cond_sel;
    logic [1:0] tx_irq_level;
    logic fifo_enable_cfg;
    sfcs_duplex_t duplex_mode;
    logic rx_overrun_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] irq_event;
    logic [2:0] next_irq_status;
    logic [31:0] next_prdata;
    sfcs_level_t rx_cap;
    sfcs_level_t tx_cap;
    sfcs_level_t rx_thr;
    sfcs_level_t tx_thr;
    sfcs_level_t rx_level;
    sfcs_level_t tx_level;
    sfcs_level_t rx_next;
    sfcs_level_t tx_next;
    logic rx_wr_ok;
    logic rx_rd_ok;
    logic tx_wr_ok;
    logic tx_rd_ok;
    logic rx_hit;
    logic tx_hit;
    logic rx_ovf;

    // Zero wait state slave: every access phase completes at once.
    assign setup = I_PSEL && !I_PENABLE;
    assign access = I_PSEL && I_PENABLE;
    assign wr_en = access && I_PWRITE && hit;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = access && !hit;

    always_comb begin
        unique case (I_PADDR)
            `SFCS_OFF_RX_CFG, `SFCS_OFF_TX_CFG, `SFCS_OFF_RX_STAT, `SFCS_OFF_CTRL,
            `SFCS_OFF_TX_STAT, `SFCS_OFF_IRQ_STAT, `SFCS_OFF_IRQ_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Clear strobes act in the write cycle and are never stored.
    assign rx_clr = wr_en && (I_PADDR == `SFCS_OFF_RX_CFG) && I_PWDATA[`SFCS_CFG_CLR_BIT];
    assign tx_clr = wr_en && (I_PADDR == `SFCS_OFF_TX_CFG) && I_PWDATA[`SFCS_CFG_CLR_BIT];

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rx_cond_sel <= 1'b0;
            rx_irq_level <= `SFCS_RST_LVL;
        end else if (wr_en && (I_PADDR == `SFCS_OFF_RX_CFG)) begin
            rx_cond_sel <= I_PWDATA[`SFCS_CFG_SEL_BIT];
            rx_irq_level <= I_PWDATA[`SFCS_CFG_LVL_HI:`SFCS_CFG_LVL_LO];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            tx_cond_sel <= 1'b0;
            tx_irq_level <= `SFCS_RST_LVL;
        end else if (wr_en && (I_PADDR == `SFCS_OFF_TX_CFG)) begin
            tx_cond_sel <= I_PWDATA[`SFCS_CFG_SEL_BIT];
            tx_irq_level <= I_PWDATA[`SFCS_CFG_LVL_HI:`SFCS_CFG_LVL_LO];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fifo_enable_cfg <= 1'b0;
            duplex_mode <= SFCS_DPX_OFF;
        end else if (wr_en && (I_PADDR == `SFCS_OFF_CTRL)) begin
            fifo_enable_cfg <= I_PWDATA[`SFCS_CTRL_EN_BIT];
            duplex_mode <= sfcs_duplex_t'(I_PWDATA[`SFCS_CTRL_DPX_HI:`SFCS_CTRL_DPX_LO]);
        end
    end

    assign O_FIFO_ENABLE = fifo_enable_cfg;
    assign O_DUPLEX_MODE = duplex_mode;

    // Without the FIFO, or for the idle direction, a single byte buffer remains.
    always_comb begin
        rx_cap = `SFCS_DEPTH_NONE;
        tx_cap = `SFCS_DEPTH_NONE;
        if (fifo_enable_cfg) begin
            unique case (duplex_mode)
                SFCS_DPX_HALF_RX: rx_cap = `SFCS_DEPTH_HALF;
                SFCS_DPX_HALF_TX: tx_cap = `SFCS_DEPTH_HALF;
                SFCS_DPX_FULL: begin
                    rx_cap = `SFCS_DEPTH_FULL;
                    tx_cap = `SFCS_DEPTH_FULL;
                end
                SFCS_DPX_OFF: begin
                    rx_cap = `SFCS_DEPTH_NONE;
                    tx_cap = `SFCS_DEPTH_NONE;
                end
            endcase
        end
    end

    always_comb begin
        if (duplex_mode == SFCS_DPX_FULL) begin
            rx_thr = rx_irq_level[0] ? 3'h1 : 3'h2;
        end else begin
            rx_thr = (rx_irq_level == 2'h0) ? 3'h4 : {1'b0, rx_irq_level};
        end
    end

    always_comb begin
        if (duplex_mode == SFCS_DPX_FULL) begin
            tx_thr = {2'h0, tx_irq_level[0]};
        end else begin
            tx_thr = {1'b0, tx_irq_level};
        end
    end

    sfcs_fifo u_rx_fifo (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_clr(rx_clr),
        .i_wr(I_RX_WR),
        .i_data(I_RX_DATA),
        .i_rd(I_RX_RD),
        .i_cap(rx_cap),
        .o_data(O_RX_DATA),
        .o_wr_ok(rx_wr_ok),
        .o_rd_ok(rx_rd_ok),
        .o_level(rx_level),
        .o_next_level(rx_next)
    );

    sfcs_fifo u_tx_fifo (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_clr(tx_clr),
        .i_wr(I_TX_WR),
        .i_data(I_TX_DATA),
        .i_rd(I_TX_RD),
        .i_cap(tx_cap),
        .o_data(O_TX_DATA),
        .o_wr_ok(tx_wr_ok),
        .o_rd_ok(tx_rd_ok),
        .o_level(tx_level),
        .o_next_level(tx_next)
    );

    assign O_RX_READY = rx_level < rx_cap;
    assign O_RX_VALID = rx_level != 3'h0;
    assign O_TX_READY = tx_level < tx_cap;
    assign O_TX_VALID = tx_level != 3'h0;

    // Comparisons run only in cycles with FIFO activity, so a steady level fires once.
    assign rx_hit = (rx_wr_ok || rx_rd_ok || rx_clr) &&
        ((rx_next == rx_thr) || (rx_cond_sel && rx_rd_ok && (rx_level > rx_thr)));
    assign tx_hit = (tx_wr_ok || tx_rd_ok || tx_clr) &&
        ((tx_next == tx_thr) || (tx_cond_sel && tx_rd_ok && (tx_next < tx_thr)));

    assign rx_ovf = I_RX_WR && !rx_clr && (rx_level >= rx_cap);

    // The overrun flag stays set until the receive FIFO is cleared.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST || rx_clr) begin
            rx_overrun_flag <= 1'b0;
        end else if (rx_ovf) begin
            rx_overrun_flag <= 1'b1;
        end
    end

    always_comb begin
        irq_event = 3'h0;
        irq_event[`SFCS_IRQ_RX_BIT] = rx_hit;
        irq_event[`SFCS_IRQ_TX_BIT] = tx_hit;
        irq_event[`SFCS_IRQ_OVR_BIT] = rx_ovf;
        next_irq_status = irq_status;
        if (wr_en && (I_PADDR == `SFCS_OFF_IRQ_STAT)) begin
            next_irq_status = irq_status & ~I_PWDATA[2:0];
        end
        // A new event wins over a clear in the same cycle.
        next_irq_status = next_irq_status | irq_event;
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            irq_status <= `SFCS_RST_IRQ;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            irq_mask <= `SFCS_RST_IRQ;
        end else if (wr_en && (I_PADDR == `SFCS_OFF_IRQ_MASK)) begin
            irq_mask <= I_PWDATA[2:0];
        end
    end

    assign O_IRQ = |(irq_status & irq_mask);

    // Read data is captured in the setup cycle and shown in the access phase.
    always_comb begin
        next_prdata = `SFCS_RST_WORD;
        unique case (I_PADDR)
            `SFCS_OFF_RX_CFG: begin
                next_prdata[`SFCS_CFG_SEL_BIT] = rx_cond_sel;
                next_prdata[`SFCS_CFG_LVL_HI:`SFCS_CFG_LVL_LO] = rx_irq_level;
            end
            `SFCS_OFF_TX_CFG: begin
                next_prdata[`SFCS_CFG_SEL_BIT] = tx_cond_sel;
                next_prdata[`SFCS_CFG_LVL_HI:`SFCS_CFG_LVL_LO] = tx_irq_level;
            end
            `SFCS_OFF_RX_STAT: begin
                next_prdata[`SFCS_STAT_OVR_BIT] = rx_overrun_flag;
                next_prdata[`SFCS_STAT_LVL_HI:`SFCS_STAT_LVL_LO] = rx_level;
            end
            `SFCS_OFF_CTRL: begin
                next_prdata[`SFCS_CTRL_EN_BIT] = fifo_enable_cfg;
                next_prdata[`SFCS_CTRL_DPX_HI:`SFCS_CTRL_DPX_LO] = duplex_mode;
            end
            `SFCS_OFF_TX_STAT: next_prdata[`SFCS_STAT_LVL_HI:`SFCS_STAT_LVL_LO] = tx_level;
            `SFCS_OFF_IRQ_STAT: next_prdata[2:0] = irq_status;
            `SFCS_OFF_IRQ_MASK: next_prdata[2:0] = irq_mask;
            default: next_prdata = `SFCS_RST_WORD;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_PRDATA <= `SFCS_RST_WORD;
        end else if (setup && !I_PWRITE) begin
            O_PRDATA <= next_prdata;
        end
    end

endmodule

//--- verif/sfcs_monitor.sv
`timescale 1ns/100ps
`include "sfcs_consts.svh"
module sfcs_monitor (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PSLVERR,
    input wire logic I_RX_WR,
    input wire logic I_RX_RD,
    input wire logic O_RX_READY,
    input wire logic O_RX_VALID,
    input wire logic O_TX_READY,
    input wire logic O_TX_VALID,
    input wire logic O_FIFO_ENABLE,
    input wire sfcs_pkg::sfcs_duplex_t O_DUPLEX_MODE
);
    import sfcs_pkg::*;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic wr_ok;
    logic rd_acc;
    logic clr_rx;
    logic full;
    assign wr_ok = I_PSEL && I_PENABLE && I_PWRITE && !O_PSLVERR;
    assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
    assign clr_rx = wr_ok && I_PADDR == `SFCS_OFF_RX_CFG && I_PWDATA[7];
    assign full = O_FIFO_ENABLE && O_DUPLEX_MODE == SFCS_DPX_FULL;
    rx_clear_a: assert property (clr_rx |=> !O_RX_VALID && O_RX_READY)
        else $error("rx clear left data");
    tx_clear_a: assert property (wr_ok && I_PADDR == `SFCS_OFF_TX_CFG && I_PWDATA[7]
        |=> !O_TX_VALID && O_TX_READY) else $error("tx clear left data");
    rx_upper_a: assert property (rd_acc && I_PADDR == `SFCS_OFF_RX_CFG
        |-> O_PRDATA[31:7] == 25'h0) else $error("rx config upper bits set");
    rx_stat_a: assert property (rd_acc && I_PADDR == `SFCS_OFF_RX_STAT
        |-> O_PRDATA[31:8] == 24'h0 && O_PRDATA[6:3] == 4'h0 && O_PRDATA[2:0] <= 3'h4)
        else $error("rx status field out of range");
    rx_push_a: assert property (I_RX_WR && O_RX_READY && !clr_rx |=> O_RX_VALID)
        else $error("accepted push not visible");
    empty_hold_a: assert property (!O_RX_VALID && !I_RX_WR |=> !O_RX_VALID)
        else $error("empty fifo became valid");
    full_depth_a: assert property ((full && !O_RX_VALID && I_RX_WR && !I_RX_RD && !clr_rx)
        ##1 (full && I_RX_WR && !I_RX_RD && !clr_rx) |=> !O_RX_READY)
        else $error("full duplex depth not two");
    mode_write_a: assert property (wr_ok && I_PADDR == `SFCS_OFF_CTRL
        |=> O_FIFO_ENABLE == $past(I_PWDATA[0]) && O_DUPLEX_MODE == $past(I_PWDATA[2:1]))
        else $error("mode write not applied");
endmodule

//--- verif/sfcs_far_model.sv
`timescale 1ns/100ps
module sfcs_far_model (
    input wire logic i_clk,
    output logic o_rx_wr,
    output logic [7:0] o_rx_data,
    output logic o_tx_rd
);
    initial begin
        o_rx_wr = 1'b0;
        o_rx_data = 8'h00;
        o_tx_rd = 1'b0;
    end
    // Bytes arrive back to back; the released data line shows junk.
    task automatic push_burst(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_rx_wr <= 1'b1;
            o_rx_data <= base + 8'(i);
        end
        @(posedge i_clk);
        o_rx_wr <= 1'b0;
        o_rx_data <= ~o_rx_data;
    endtask
    task automatic pop_tx();
        @(posedge i_clk);
        o_tx_rd <= 1'b1;
        @(posedge i_clk);
        o_tx_rd <= 1'b0;
    endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
`include "sfcs_consts.svh"
`define SFCS_CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    import sfcs_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rx_rd = 0, tx_wr = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, exp_w;
    logic [7:0] tx_data = 0, rx_din, rx_dout, tx_dout, b, exp_b;
    logic pready, rx_wr, tx_rd, rx_valid, tx_valid, pslverr, irq;
    sfcs_duplex_t dpx;
    logic [31:0] exp_q[$];
    logic [7:0] rx_q[$], tx_q[$];
    int err_total = 0, comparisons = 0;
    logic [11:0] offs[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
        12'h018, 12'h1FC};
    always #20 clk = ~clk;
    sfcs_top u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_WR(rx_wr), .I_RX_DATA(rx_din),
        .I_RX_RD(rx_rd), .O_RX_DATA(rx_dout), .O_RX_READY(), .O_RX_VALID(rx_valid),
        .I_TX_WR(tx_wr), .I_TX_DATA(tx_data), .I_TX_RD(tx_rd), .O_TX_DATA(tx_dout),
        .O_TX_READY(), .O_TX_VALID(tx_valid), .O_FIFO_ENABLE(), .O_DUPLEX_MODE(dpx),
        .O_IRQ(irq));
    sfcs_far_model u_far (.i_clk(clk), .o_rx_wr(rx_wr), .o_rx_data(rx_din), .o_tx_rd(tx_rd));
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready) begin
            exp_w = exp_q.pop_front();
            `SFCS_CHK(prdata, exp_w)
        end
        if (rx_rd && rx_valid) begin
            exp_b = rx_q.pop_front();
            `SFCS_CHK(rx_dout, exp_b)
        end
        if (tx_rd && tx_valid) begin
            exp_b = tx_q.pop_front();
            `SFCS_CHK(tx_dout, exp_b)
        end
        if (psel && penable && pready) begin
            `SFCS_CHK(pslverr, (paddr > `SFCS_OFF_IRQ_MASK))
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic push_tx();
        logic [7:0] v;
        v = 8'($urandom);
        tx_q.push_back(v);
        @(posedge clk);
        tx_wr <= 1'b1;
        tx_data <= v;
        @(posedge clk);
        tx_wr <= 1'b0;
        tx_data <= ~v;
    endtask
    task automatic sweep(input logic tx, input logic [31:0] ctl, input int cap,
        input logic [11:0] thr);
        int t;
        for (int c = 0; c < 4; c++) begin
            t = thr[c*3+:3];
            apb(1'b1, `SFCS_OFF_CTRL, ctl);
            apb(1'b1, tx ? `SFCS_OFF_TX_CFG : `SFCS_OFF_RX_CFG, 32'h0000_0080 | c);
            apb(1'b1, `SFCS_OFF_IRQ_STAT, 32'h0000_0007);
            for (int n = 1; n <= cap; n++) begin
                if (tx) begin
                    push_tx();
                end else begin
                    u_far.push_burst(1, 8'($urandom));
                end
                rd(`SFCS_OFF_IRQ_STAT, 32'((t != 0 && n >= t) ? (tx ? 2 : 1) : 0));
            end
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(62));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) rd(offs[i], 32'h0000_0000);
        apb(1'b1, `SFCS_OFF_RX_CFG, 32'hFFFF_FF7F);
        rd(`SFCS_OFF_RX_CFG, 32'h0000_0043);
        $display("reset and readback done");
        sweep(1'b0, 32'h0000_0003, 4, {3'd3, 3'd2, 3'd1, 3'd4});
        sweep(1'b0, 32'h0000_0007, 2, {3'd1, 3'd2, 3'd1, 3'd2});
        apb(1'b1, `SFCS_OFF_RX_CFG, 32'h0000_0080);
        u_far.push_burst(3, 8'h00);
        rd(`SFCS_OFF_RX_STAT, 32'h0000_0082);
        sweep(1'b1, 32'h0000_0005, 4, {3'd3, 3'd2, 3'd1, 3'd0});
        sweep(1'b1, 32'h0000_0007, 2, {3'd1, 3'd0, 3'd1, 3'd0});
        #1 `SFCS_CHK(dpx, SFCS_DPX_FULL)
        $display("threshold sweep done");
        apb(1'b1, `SFCS_OFF_CTRL, 32'h0000_0003);
        apb(1'b1, `SFCS_OFF_IRQ_STAT, 32'h0000_0007);
        apb(1'b1, `SFCS_OFF_RX_CFG, 32'h0000_00C1);
        apb(1'b1, `SFCS_OFF_TX_CFG, 32'h0000_0080);
        b = 8'($urandom);
        for (int i = 0; i < 4; i++) rx_q.push_back(b + 8'(i));
        u_far.push_burst(5, b);
        rd(`SFCS_OFF_RX_STAT, 32'h0000_0084);
        rd(`SFCS_OFF_IRQ_STAT, 32'h0000_0005);
        #1 `SFCS_CHK(irq, 1'b0)
        apb(1'b1, `SFCS_OFF_IRQ_MASK, 32'h0000_0004);
        #1 `SFCS_CHK(irq, 1'b1)
        apb(1'b1, `SFCS_OFF_IRQ_STAT, 32'h0000_0007);
        #1 `SFCS_CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++) @(posedge clk) rx_rd <= 1'b1;
        @(posedge clk) rx_rd <= 1'b0;
        rd(`SFCS_OFF_IRQ_STAT, 32'h0000_0001);
        rd(`SFCS_OFF_RX_STAT, 32'h0000_0080);
        apb(1'b1, `SFCS_OFF_RX_CFG, 32'h0000_0080);
        rd(`SFCS_OFF_RX_STAT, 32'h0000_0000);
        $display("overrun and drain done");
        apb(1'b1, `SFCS_OFF_CTRL, 32'h0000_0005);
        apb(1'b1, `SFCS_OFF_TX_CFG, 32'h0000_00C2);
        tx_q.delete();
        repeat (3) push_tx();
        apb(1'b1, `SFCS_OFF_IRQ_STAT, 32'h0000_0007);
        u_far.pop_tx();
        rd(`SFCS_OFF_IRQ_STAT, 32'h0000_0002);
        apb(1'b1, `SFCS_OFF_IRQ_STAT, 32'h0000_0007);
        u_far.pop_tx();
        rd(`SFCS_OFF_IRQ_STAT, 32'h0000_0002);
        $display("transmit drain done");
        conclude();
    end
endmodule
bind sfcs_top sfcs_monitor u_mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .I_RX_WR(I_RX_WR), .I_RX_RD(I_RX_RD),
    .O_RX_READY(O_RX_READY), .O_RX_VALID(O_RX_VALID), .O_TX_READY(O_TX_READY),
    .O_TX_VALID(O_TX_VALID), .O_FIFO_ENABLE(O_FIFO_ENABLE), .O_DUPLEX_MODE(O_DUPLEX_MODE));
